// ---- shift_storage_reg.sv ----
// Universal shift/storage register with three-state parallel port and APB view
module shift_storage_reg (
  input wire logic CLK, // System clock, 10 MHz
  input wire logic RST_B, // Chip reset, active low, async
  input wire logic SHIFT_CLOCK, // Shift clock, acts on its rise
  input wire logic MODE_SELECT_LOW, // Mode select, low bit
  input wire logic MODE_SELECT_HIGH, // Mode select, high bit
  input wire logic MASTER_CLEAR_N, // Master clear, active low, async
  input wire logic RIGHT_SHIFT_SERIAL_IN, // Serial in for right shift
  input wire logic LEFT_SHIFT_SERIAL_IN, // Serial in for left shift
  input wire logic PORT_ENABLE_A_N, // Parallel enable A, active low
  input wire logic PORT_ENABLE_B_N, // Parallel enable B, active low
  input wire logic [7:0] PAR_IN, // Parallel pins, input side
  output logic [7:0] PAR_OUT, // Parallel pins, output side
  output logic [7:0] PAR_OE, // Parallel pins, drive enable
  output logic LOW_END_SERIAL_OUT, // Serial out, bit 0
  output logic HIGH_END_SERIAL_OUT, // Serial out, bit 7
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB enable
  input wire logic PWRITE, // APB direction
  input wire logic [11:0] PADDR, // APB byte address
  input wire logic [31:0] PWDATA, // APB write data
  output logic [31:0] PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR // APB error
);

  logic raw_rst_n;
  logic [1:0] rst_sync_q;
  logic rst_n;
  shift_reg_pkg::state_t s_q;
  shift_reg_pkg::state_t s_d;
  shift_reg_pkg::apb_req_t req;
  logic [1:0] mode;
  logic rise;
  logic drive;
  logic clr_now;

  // Address decode used by the error answer and its check; the read mux decodes the address itself
  function automatic logic addr_known(input logic [shift_reg_pkg::ADDR_W-1:0] a);
    addr_known = (a == shift_reg_pkg::OFF_DATA) || (a == shift_reg_pkg::OFF_CTRL) ||
                 (a == shift_reg_pkg::OFF_STATUS);
  endfunction : addr_known

  // Read mux; control reads as zero because its clear bit self-clears
  function automatic logic [shift_reg_pkg::DATA_W-1:0] read_word(
    input logic [shift_reg_pkg::ADDR_W-1:0] a,
    input logic [shift_reg_pkg::WIDTH-1:0] b,
    input logic [1:0] m,
    input logic d,
    input logic c
  );
    logic [shift_reg_pkg::DATA_W-1:0] w;
    w = shift_reg_pkg::WORD_ZERO;
    if (a == shift_reg_pkg::OFF_DATA) begin
      w[shift_reg_pkg::WIDTH-1:0] = b;
    end else if (a == shift_reg_pkg::OFF_STATUS) begin
      w[shift_reg_pkg::STAT_MODE_LSB +: 2] = m;
      w[shift_reg_pkg::STAT_DRIVE_BIT] = d;
      w[shift_reg_pkg::STAT_CLOCK_BIT] = c;
    end
    read_word = w;
  endfunction : read_word

  // Either reset pin clears at once; release is resynchronised to CLK
  assign raw_rst_n = RST_B & MASTER_CLEAR_N;

  // Reset synchroniser, asserts asynchronously, releases after two edges
  always_ff @(posedge CLK or negedge raw_rst_n) begin
    if (!raw_rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'h1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // Bus request bundled for the decode below; one driver for the whole carrier
  assign req = '{
    psel: PSEL,
    penable: PENABLE,
    pwrite: PWRITE,
    paddr: PADDR,
    pwdata: PWDATA
  };

  // Mode pins and shift clock rise; clock level starts high so no false edge at release
  assign mode = {MODE_SELECT_HIGH, MODE_SELECT_LOW};
  assign rise = !s_q.clock_level && SHIFT_CLOCK;

  // Parallel drive: both enables low and not in load mode
  assign drive = !PORT_ENABLE_A_N && !PORT_ENABLE_B_N && (mode != shift_reg_pkg::MODE_LOAD);

  // Software clear takes effect at the completing edge of a control write
  assign clr_now = (s_q.phase == shift_reg_pkg::AP_ANS) && req.psel && req.penable && req.pwrite &&
                   (req.paddr == shift_reg_pkg::OFF_CTRL) && req.pwdata[shift_reg_pkg::CTRL_CLEAR_BIT];

  // Next state: storage update, then bus slave
  always_comb begin
    s_d = s_q;
    s_d.clock_level = SHIFT_CLOCK;
    // Enables are not consulted here, so floated pins keep working internally
    if (rise) begin
      case (mode)
        shift_reg_pkg::MODE_HOLD: begin
          s_d.bits = s_q.bits;
        end
        shift_reg_pkg::MODE_RIGHT: begin
          s_d.bits = {s_q.bits[shift_reg_pkg::WIDTH-2:0], RIGHT_SHIFT_SERIAL_IN};
        end
        shift_reg_pkg::MODE_LEFT: begin
          s_d.bits = {LEFT_SHIFT_SERIAL_IN, s_q.bits[shift_reg_pkg::WIDTH-1:1]};
        end
        shift_reg_pkg::MODE_LOAD: begin
          s_d.bits = PAR_IN;
        end
        default: begin
          s_d.bits = s_q.bits;
        end
      endcase
    end
    // Answer is prepared in the setup cycle, so every access has no wait state
    case (s_q.phase)
      shift_reg_pkg::AP_IDLE: begin
        if (req.psel && !req.penable) begin
          s_d.phase = shift_reg_pkg::AP_ANS;
          s_d.rsp.pready = 1'h1;
          s_d.rsp.pslverr = !addr_known(req.paddr) || (req.pwrite && (req.paddr != shift_reg_pkg::OFF_CTRL));
          s_d.rsp.prdata = req.pwrite ? shift_reg_pkg::WORD_ZERO :
                           read_word(req.paddr, s_q.bits, mode, drive, s_q.clock_level);
        end
      end
      shift_reg_pkg::AP_ANS: begin
        if (req.psel && req.penable) begin
          s_d.phase = shift_reg_pkg::AP_IDLE;
          s_d.rsp.pready = 1'h0;
          s_d.rsp.pslverr = 1'h0;
          s_d.rsp.prdata = shift_reg_pkg::WORD_ZERO;
        end
      end
      default: begin
        s_d.phase = shift_reg_pkg::AP_IDLE;
      end
    endcase
    // Clear beats a shift edge arriving in the same cycle
    if (clr_now) begin
      s_d.bits = shift_reg_pkg::BITS_RST;
    end
  end

  // State register; reset clears storage without waiting for a clock
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      s_q.phase <= shift_reg_pkg::AP_IDLE;
      s_q.clock_level <= shift_reg_pkg::CLOCK_LEVEL_RST;
      s_q.bits <= shift_reg_pkg::BITS_RST;
      s_q.rsp <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state flops
  assign PAR_OUT = s_q.bits;
  assign LOW_END_SERIAL_OUT = s_q.bits[0];
  assign HIGH_END_SERIAL_OUT = s_q.bits[shift_reg_pkg::WIDTH-1];
  assign PRDATA = s_q.rsp.prdata;
  assign PREADY = s_q.rsp.pready;
  assign PSLVERR = s_q.rsp.pslverr;

  // Enable per pin; kept unregistered so floating follows the pins at once
  genvar gi;
  generate
    for (gi = 0; gi < shift_reg_pkg::WIDTH; gi++) begin : g_pin_oe
      assign PAR_OE[gi] = drive;
    end
  endgenerate

  // Checks on the storage, the port and the bus answer
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  // Master clear empties storage and both ends, clock or not
  property p_clear;
    @(posedge CLK) disable iff (1'b0)
    !MASTER_CLEAR_N |-> (PAR_OUT == shift_reg_pkg::BITS_RST) && !LOW_END_SERIAL_OUT && !HIGH_END_SERIAL_OUT;
  endproperty
  a_clear: assert property (p_clear) else $error("master clear did not empty the register");

  // Hold mode keeps every bit
  property p_hold;
    rise && (mode == shift_reg_pkg::MODE_HOLD) && !clr_now |=> PAR_OUT == $past(PAR_OUT);
  endproperty
  a_hold: assert property (p_hold) else $error("hold mode changed the register");

  // Whole byte switches together
  property p_width;
    drive |-> (PAR_OE == 8'hFF);
  endproperty
  a_width: assert property (p_width) else $error("not all eight parallel pins driven");

  // Load captures the resolved pin levels
  property p_load;
    rise && (mode == shift_reg_pkg::MODE_LOAD) && !clr_now |=> PAR_OUT == $past(PAR_IN);
  endproperty
  a_load: assert property (p_load) else $error("load did not capture parallel pins");

  // Load mode floats the port at once
  property p_float_load;
    MODE_SELECT_LOW && MODE_SELECT_HIGH |-> (PAR_OE == 8'h00);
  endproperty
  a_float_load: assert property (p_float_load) else $error("pins driven in load mode");

  // Right shift moves bits upward
  property p_right;
    rise && (mode == shift_reg_pkg::MODE_RIGHT) && !clr_now
      |=> PAR_OUT == {$past(PAR_OUT[6:0]), $past(RIGHT_SHIFT_SERIAL_IN)};
  endproperty
  a_right: assert property (p_right) else $error("right shift wrong");

  // Left shift moves bits downward
  property p_left;
    rise && (mode == shift_reg_pkg::MODE_LEFT) && !clr_now
      |=> PAR_OUT == {$past(LEFT_SHIFT_SERIAL_IN), $past(PAR_OUT[7:1])};
  endproperty
  a_left: assert property (p_left) else $error("left shift wrong");

  // Either enable high floats the port
  property p_enables;
    PORT_ENABLE_A_N || PORT_ENABLE_B_N |-> (PAR_OE == 8'h00);
  endproperty
  a_enables: assert property (p_enables) else $error("pins driven with an enable high");

  // Floated port must not stall the shifter
  property p_internal;
    PORT_ENABLE_A_N && rise && (mode == shift_reg_pkg::MODE_RIGHT) && !clr_now
      |=> LOW_END_SERIAL_OUT == $past(RIGHT_SHIFT_SERIAL_IN);
  endproperty
  a_internal: assert property (p_internal) else $error("shift stopped while pins floated");

  // Serial ends track the end flops
  property p_ends;
    (LOW_END_SERIAL_OUT == PAR_OUT[0]) && (HIGH_END_SERIAL_OUT == PAR_OUT[7]);
  endproperty
  a_ends: assert property (p_ends) else $error("serial end outputs disagree with storage");

  // Driven pin shows the bit just shifted in
  property p_present;
    rise && (mode == shift_reg_pkg::MODE_LEFT) && !clr_now ##1 drive
      |-> PAR_OE[7] && (PAR_OUT[7] == $past(LEFT_SHIFT_SERIAL_IN));
  endproperty
  a_present: assert property (p_present) else $error("driven pin does not show latest bit");

  // Nothing moves between shift edges
  property p_edge_only;
    !rise && !clr_now |=> $stable(PAR_OUT);
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("storage changed without a clock rise");

  // Answer is a one-cycle pulse after the setup edge
  property p_ready;
    (s_q.phase == shift_reg_pkg::AP_IDLE) && PSEL && !PENABLE |=> PREADY ##1 !PREADY [*1];
  endproperty
  a_ready: assert property (p_ready) else $error("APB answer not one access cycle");

  // Software clear empties storage and both serial ends
  property p_sw_clear;
    clr_now
      |=> (PAR_OUT == shift_reg_pkg::BITS_RST) && !LOW_END_SERIAL_OUT && !HIGH_END_SERIAL_OUT;
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("control write did not clear the register");

  // Both enables low outside load mode turns every pin on
  property p_drive_on;
    !PORT_ENABLE_A_N && !PORT_ENABLE_B_N && (mode != shift_reg_pkg::MODE_LOAD)
      |-> (PAR_OE == 8'hFF);
  endproperty
  a_drive_on: assert property (p_drive_on) else $error("pins floated with both enables low");

  // Right shift: low end takes the serial bit, high end the old bit six
  property p_right_ends;
    rise && (mode == shift_reg_pkg::MODE_RIGHT) && !clr_now
      |=> (LOW_END_SERIAL_OUT == $past(RIGHT_SHIFT_SERIAL_IN)) && (HIGH_END_SERIAL_OUT == $past(PAR_OUT[6]));
  endproperty
  a_right_ends: assert property (p_right_ends) else $error("serial ends wrong after right shift");

  // Floated port: both ends still follow a left shift
  property p_left_ends;
    PORT_ENABLE_B_N && rise && (mode == shift_reg_pkg::MODE_LEFT) && !clr_now
      |=> (HIGH_END_SERIAL_OUT == $past(LEFT_SHIFT_SERIAL_IN)) && (LOW_END_SERIAL_OUT == $past(PAR_OUT[1]));
  endproperty
  a_left_ends: assert property (p_left_ends) else $error("serial ends stopped while pins floated");

  // A shift edge needs a fresh low sample before the next one
  property p_single_edge;
    rise |=> !rise;
  endproperty
  a_single_edge: assert property (p_single_edge) else $error("two shift edges on adjacent samples");

  // Unmapped address answers with an error and zero data
  property p_err_unmapped;
    (s_q.phase == shift_reg_pkg::AP_IDLE) && PSEL && !PENABLE && !addr_known(PADDR)
      |=> PREADY && PSLVERR && (PRDATA == shift_reg_pkg::WORD_ZERO);
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");

  // Writes anywhere but control are refused
  property p_write_refused;
    (s_q.phase == shift_reg_pkg::AP_IDLE) && PSEL && !PENABLE && PWRITE && (PADDR != shift_reg_pkg::OFF_CTRL)
      |=> PREADY && PSLVERR;
  endproperty
  a_write_refused: assert property (p_write_refused) else $error("write to read-only word accepted");

  // Control write is taken without error
  property p_ctrl_write;
    (s_q.phase == shift_reg_pkg::AP_IDLE) && PSEL && !PENABLE && PWRITE && (PADDR == shift_reg_pkg::OFF_CTRL)
      |=> PREADY && !PSLVERR;
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write answered with error");

  // Data read returns the byte stored at the setup edge
  property p_read_data;
    (s_q.phase == shift_reg_pkg::AP_IDLE) && PSEL && !PENABLE && !PWRITE && (PADDR == shift_reg_pkg::OFF_DATA)
      |=> !PSLVERR && (PRDATA[shift_reg_pkg::WIDTH-1:0] == $past(PAR_OUT));
  endproperty
  a_read_data: assert property (p_read_data) else $error("data read does not match storage");

  // Status read mirrors mode pins, drive state and clock level
  property p_read_status;
    (s_q.phase == shift_reg_pkg::AP_IDLE) && PSEL && !PENABLE && !PWRITE && (PADDR == shift_reg_pkg::OFF_STATUS)
      |=> (PRDATA[shift_reg_pkg::STAT_MODE_LSB +: 2] == $past(mode)) &&
          (PRDATA[shift_reg_pkg::STAT_DRIVE_BIT] == $past(PAR_OE[0])) &&
          (PRDATA[shift_reg_pkg::STAT_CLOCK_BIT] == $past(s_q.clock_level));
  endproperty
  a_read_status: assert property (p_read_status) else $error("status read does not match pins");

  // Answer lines rest at zero between transfers
  property p_quiet_bus;
    !PREADY |-> (PRDATA == shift_reg_pkg::WORD_ZERO) && !PSLVERR;
  endproperty
  a_quiet_bus: assert property (p_quiet_bus) else $error("bus answer lines not idle");

  c_load: cover property (rise && (mode == shift_reg_pkg::MODE_LOAD) && PAR_IN != 8'h00);
  c_bus_error: cover property (PREADY && PSLVERR);
  c_right_left: cover property (rise && (mode == shift_reg_pkg::MODE_RIGHT) ##[1:20]
                                rise && (mode == shift_reg_pkg::MODE_LEFT));
  c_float_shift: cover property (PORT_ENABLE_B_N && rise && (mode == shift_reg_pkg::MODE_LEFT));
  c_sw_clear: cover property (clr_now && PAR_OUT != 8'h00);

endmodule : shift_storage_reg

// ---- shift_reg_pkg.sv ----
// Constants, types and register map of the universal shift/storage register
package shift_reg_pkg;

  localparam int unsigned WIDTH = 8;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // Mode codes, indexed as {mode_select_high, mode_select_low}
  localparam logic [1:0] MODE_HOLD = 2'h0;
  localparam logic [1:0] MODE_LEFT = 2'h1;
  localparam logic [1:0] MODE_RIGHT = 2'h2;
  localparam logic [1:0] MODE_LOAD = 2'h3;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_DATA = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h008;

  // Field positions
  localparam int unsigned CTRL_CLEAR_BIT = 0;
  localparam int unsigned STAT_MODE_LSB = 0;
  localparam int unsigned STAT_DRIVE_BIT = 2;
  localparam int unsigned STAT_CLOCK_BIT = 3;

  // Reset values
  localparam logic [WIDTH-1:0] BITS_RST = 8'h00;
  localparam logic CLOCK_LEVEL_RST = 1'h1;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h00000000;

  typedef enum logic [0:0] {AP_IDLE, AP_ANS} apb_phase_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    apb_phase_t phase;
    logic clock_level;
    logic [WIDTH-1:0] bits;
    apb_rsp_t rsp;
  } state_t;

endpackage : shift_reg_pkg

// ---- board_side.sv ----
// Board logic model that resolves the shared parallel pins
module board_side (
  input wire logic clk, // Board clock
  input wire logic [7:0] dev_out, // Device pin value
  input wire logic [7:0] dev_oe, // Device drives pin
  input wire logic drv_en, // Board drives pins
  input wire logic [7:0] drv_val, // Board pin value
  output logic [7:0] pins // Resolved pin level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last_q = 8'h00;
  // No pull-up: a floating pin toggles so a stale value never passes
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pins[i] = dev_oe[i] ? dev_out[i] : (drv_en ? drv_val[i] : ~last_q[i]);
    end
  end
  // Remember the last level for the float pattern
  always_ff @(posedge clk) begin
    last_q <= pins;
  end
endmodule : board_side

// ---- tb.sv ----
// Self-checking bench for the shift/storage register
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_b = 0, sck = 1, msl = 0, msh = 0, mclr_n = 1, rsi = 0, lsi = 0;
  logic ena_n = 0, enb_n = 0, psel = 0, penable = 0, pwrite = 0, drv_en = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic [7:0] par_in, par_out, par_oe, drv_val = 8'h00;
  logic q_lo, q_hi, pready, pslverr, err;
  int failures = 0;
  int checks = 0;
  initial forever #50 clk = ~clk;
  shift_storage_reg shift_storage_reg_inst (.CLK(clk), .RST_B(rst_b), .SHIFT_CLOCK(sck),
    .MODE_SELECT_LOW(msl), .MODE_SELECT_HIGH(msh), .MASTER_CLEAR_N(mclr_n),
    .RIGHT_SHIFT_SERIAL_IN(rsi), .LEFT_SHIFT_SERIAL_IN(lsi), .PORT_ENABLE_A_N(ena_n),
    .PORT_ENABLE_B_N(enb_n), .PAR_IN(par_in), .PAR_OUT(par_out), .PAR_OE(par_oe),
    .LOW_END_SERIAL_OUT(q_lo), .HIGH_END_SERIAL_OUT(q_hi), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr));
  board_side board_side_inst (.clk(clk), .dev_out(par_out), .dev_oe(par_oe), .drv_en(drv_en),
    .drv_val(drv_val), .pins(par_in));
  // Verdict and end of run
  task automatic summarize;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // One shift clock rise; mode and serial data set a cycle ahead of it
  task automatic step(input logic [1:0] m, input logic r, input logic l);
    @(posedge clk);
    {msh, msl} <= m;
    rsi <= r;
    lsi <= l;
    sck <= 1'b0;
    @(posedge clk);
    sck <= 1'b1;
    @(posedge clk);
    #1;
  endtask : step
  // Parallel value and both serial ends together
  task automatic chk_pins(input logic [7:0] e);
    `CHK("par_out", e, par_out)
    `CHK("low_end", e[0], q_lo)
    `CHK("high_end", e[7], q_hi)
  endtask : chk_pins
  // APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    // A lost answer counts once and skips straight to the verdict
    if (pready !== 1'b1) begin
      failures++;
      $display("wrong value apb_ready expected 1 seen %b", pready);
      disable run;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  initial begin
    begin : run
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk_pins(8'h00);
      $display("test reset done");
      @(posedge clk);
      drv_val <= 8'hA5;
      drv_en <= 1'b1;
      step(shift_reg_pkg::MODE_LOAD, 1'b0, 1'b0);
      `CHK("oe_load", 8'h00, par_oe)
      chk_pins(8'hA5);
      @(posedge clk);
      drv_en <= 1'b0;
      step(shift_reg_pkg::MODE_RIGHT, 1'b1, 1'b0);
      chk_pins(8'h4B);
      step(shift_reg_pkg::MODE_LEFT, 1'b0, 1'b1);
      chk_pins(8'hA5);
      step(shift_reg_pkg::MODE_HOLD, 1'b1, 1'b1);
      chk_pins(8'hA5);
      `CHK("oe_on", 8'hFF, par_oe)
      `CHK("pins", 8'hA5, par_in)
      $display("test modes done");
      // Each enable alone floats the port; shifts go on behind it
      @(posedge clk);
      ena_n <= 1'b1;
      step(shift_reg_pkg::MODE_RIGHT, 1'b0, 1'b0);
      `CHK("oe_a_off", 8'h00, par_oe)
      chk_pins(8'h4A);
      @(posedge clk);
      ena_n <= 1'b0;
      enb_n <= 1'b1;
      #1;
      `CHK("oe_b_off", 8'h00, par_oe)
      step(shift_reg_pkg::MODE_LEFT, 1'b0, 1'b1);
      `CHK("oe_b_left", 8'h00, par_oe)
      chk_pins(8'hA5);
      @(posedge clk);
      enb_n <= 1'b0;
      // Clock held high: no further edge, so nothing moves
      repeat (4) @(posedge clk);
      #1;
      chk_pins(8'hA5);
      $display("test enables done");
      apb(1'b0, shift_reg_pkg::OFF_DATA, 32'h00000000);
      `CHK("data_rd", 32'h000000A5, rd)
      `CHK("data_err", 1'b0, err)
      apb(1'b0, shift_reg_pkg::OFF_STATUS, 32'h00000000);
      `CHK("status_rd", 32'h0000000D, rd)
      apb(1'b0, 12'h00C, 32'h00000000);
      `CHK("unmapped", 1'b1, err)
      `CHK("unmapped_rd", 32'h00000000, rd)
      apb(1'b1, shift_reg_pkg::OFF_DATA, 32'h000000FF);
      `CHK("data_wr_err", 1'b1, err)
      @(posedge clk);
      #1;
      chk_pins(8'hA5);
      apb(1'b1, shift_reg_pkg::OFF_CTRL, 32'h00000001);
      `CHK("ctrl_err", 1'b0, err)
      @(posedge clk);
      #1;
      chk_pins(8'h00);
      $display("test bus done");
      @(posedge clk);
      drv_val <= 8'hFF;
      drv_en <= 1'b1;
      step(shift_reg_pkg::MODE_LOAD, 1'b0, 1'b0);
      chk_pins(8'hFF);
      // Master clear held across an edge, then a shift after release
      @(posedge clk);
      drv_en <= 1'b0;
      mclr_n <= 1'b0;
      #1;
      chk_pins(8'h00);
      @(posedge clk);
      mclr_n <= 1'b1;
      repeat (3) @(posedge clk);
      step(shift_reg_pkg::MODE_RIGHT, 1'b1, 1'b0);
      chk_pins(8'h01);
      $display("test clear done");
    end
    summarize();
  end
endmodule : tb
